// ===== ptei_far_model.sv
// Far side model: core, crossbar and interrupt controller observers
`timescale 1ns/1ps
module ptei_far_model #(
    parameter int N_TASK = 4,
    parameter int N_EVT = 4
) (
    // Clock
    input wire logic mclk,
    // Observation clear
    input wire logic clr_seen,
    // Pulses and level from the block
    input wire logic [N_TASK-1:0] core_task,
    input wire logic [N_EVT-1:0] xbar_evt_out,
    input wire logic irq,
    // Accumulated views
    output logic [N_TASK-1:0] task_seen,
    output logic [N_EVT-1:0] evt_seen,
    output logic [7:0] irq_cycles
);
    // Only this one peer is ever enabled on its identifier
    // Mask is wiped with an all-ones clear before reuse
    // Core and crossbar collect every pulse they see
    always_ff @(posedge mclk) begin
        if (clr_seen) begin
            task_seen <= '0;
            evt_seen <= '0;
        end else begin
            task_seen <= task_seen | core_task;
            evt_seen <= evt_seen | xbar_evt_out;
        end
    end
    // Interrupt controller counts asserted cycles, saturating
    always_ff @(posedge mclk) begin
        if (clr_seen) begin
            irq_cycles <= 8'h00;
        end else if (irq && irq_cycles != 8'hff) begin
            irq_cycles <= irq_cycles + 8'h01;
        end
    end
endmodule

// ===== ptei_pkg.sv
// Shared constants for the peripheral task/event interface block
package ptei_pkg;
    // Peripheral region and slot geometry
    localparam logic [31:0] PTEI_REGION_BASE = 32'h4000_0000;
    localparam int PTEI_SLOT_BYTES = 32'h0000_1000;
    localparam int PTEI_SLOT_WORDS = 1024;
    localparam int PTEI_SLOT_LSB = 12;
    localparam int PTEI_WORD_W = 10;
    localparam int PTEI_PID_W = 6;
    localparam int PTEI_MAX_PID = 63;
    localparam int PTEI_MAX_SHORT = 32;
    localparam int PTEI_MAX_EVT = 32;
    localparam int PTEI_MAX_TASK = 64;
    // Word indices inside the slot (byte offset / 4)
    localparam logic [9:0] PTEI_TASK_W = 10'h000;
    localparam logic [9:0] PTEI_EVT_W = 10'h040;
    localparam logic [9:0] PTEI_SHORT_W = 10'h080;
    localparam logic [9:0] PTEI_IRQ_ENABLE_MASK_W = 10'h0c0;
    localparam logic [9:0] PTEI_INTSET_W = 10'h0c1;
    localparam logic [9:0] PTEI_INTCLR_W = 10'h0c2;
    localparam logic [9:0] PTEI_ENABLE_W = 10'h140;
    // Field positions and reset values
    localparam int PTEI_TRIG_BIT = 0;
    localparam int PTEI_EVT_BIT = 0;
    localparam int PTEI_ENABLE_BIT = 0;
    localparam logic [31:0] PTEI_RESET_VAL = 32'h0000_0000;
    // Longest time for a clear to reach the interrupt line
    localparam int PTEI_CLR_MAX_CYC = 4;
endpackage

// ===== ptei_setclr.sv
// Register with main, set alias and clear alias write ports
`timescale 1ns/1ps
module ptei_setclr #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write strobes for main, set and clear addresses
    input wire logic wr_main,
    input wire logic wr_set,
    input wire logic wr_clr,
    input wire logic [W-1:0] wdata,
    // Current contents
    output logic [W-1:0] value
);
    import ptei_pkg::*;

    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    // Width must fit one bus word
    if (W < 1 || W > 32) begin : g_bad_w
        $error("ptei_setclr width out of range");
    end

    // Main write loads the word; on set and clear writes ones set or clear a bit, zeros leave it alone
    always_comb begin
        val_d = val_q;
        if (wr_main) begin
            val_d = wdata;
        end else if (wr_set) begin
            val_d = val_q | wdata;
        end else if (wr_clr) begin
            val_d = val_q & ~wdata;
        end
    end

    // Storage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            val_q <= PTEI_RESET_VAL[W-1:0];
        end else begin
            val_q <= val_d;
        end
    end

    assign value = val_q;
endmodule

// ===== ptei_top.sv
// Task, event, shortcut and interrupt register bank of one peripheral
// Function
// - Decode one 4 KiB slot of 1024 words
// - Identifier is slot index from region base
// - Tasks, events inert until peripheral enabled
// - Main, set, clear at consecutive words
// - Set ones set bits, clear ones clear
// - Alias reads return main register contents
// - Task fires on software one or pulse
// - Event pulse sets its own event register
// - Event register cleared only by writing zero
// - Event pulses continue while register set
// - Enabled shortcut links fixed event to task
// - One shortcut register, bit per shortcut
// - One interrupt line numbered by identifier
// - Each event owns a mask bit position
// - Alias reads give mask without main register
// - Clear reaches interrupt within four cycles
`timescale 1ns/1ps
module ptei_top #(
    parameter int N_TASK = 4,
    parameter int N_EVT = 4,
    parameter int N_SHORT = 4,
    parameter logic [31:0] SLOT_BASE = 32'h4000_1000,
    parameter bit HAS_MAIN = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register access
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Peripheral core side
    input wire logic [N_EVT-1:0] core_evt,
    output logic [N_TASK-1:0] core_task,
    // Event-task crossbar side
    input wire logic [N_TASK-1:0] xbar_task_in,
    output logic [N_EVT-1:0] xbar_evt_out,
    // Interrupt controller side
    output logic irq,
    output logic [ptei_pkg::PTEI_PID_W-1:0] irq_num,
    // Status
    output logic periph_enabled
);
    import ptei_pkg::*;

    localparam logic [31:0] PID_FULL =
        (SLOT_BASE - PTEI_REGION_BASE) >> PTEI_SLOT_LSB;
    localparam logic [PTEI_PID_W-1:0] PID = PID_FULL[PTEI_PID_W-1:0];

    // Refuse counts and slot bases the logic cannot serve
    if (N_TASK < 1 || N_TASK > PTEI_MAX_TASK ||
        N_EVT < 1 || N_EVT > PTEI_MAX_EVT ||
        N_SHORT < 0 || N_SHORT > PTEI_MAX_SHORT) begin : g_bad_cnt
        $error("ptei_top channel counts out of range");
    end
    if (SLOT_BASE < PTEI_REGION_BASE ||
        SLOT_BASE[PTEI_SLOT_LSB-1:0] != '0 ||
        PID_FULL > PTEI_MAX_PID) begin : g_bad_slot
        $error("ptei_top slot base not a valid slot");
    end

    logic hit;
    logic [PTEI_WORD_W-1:0] word;
    logic wr_ok;
    logic enable_q;
    logic [N_EVT-1:0] ev_gated;
    logic [N_EVT-1:0] evt_q;
    logic [N_EVT-1:0] evt_clr;
    logic [N_TASK-1:0] sw_task;
    logic [N_TASK-1:0] sc_fire;
    logic [N_TASK-1:0] task_q;
    logic [N_EVT-1:0] xbar_evt_q;
    logic [PTEI_MAX_SHORT-1:0] short_q;
    logic [N_EVT-1:0] irq_enable_mask;
    logic irq_q;
    logic [PTEI_PID_W-1:0] pid_q;
    logic [31:0] rd_word;
    logic [31:0] rdata_q;
    logic rvalid_q;

    // Slot decode: upper bits pick the slot, low bits the word
    assign hit = reg_addr[31:PTEI_SLOT_LSB] ==
                 SLOT_BASE[31:PTEI_SLOT_LSB];
    assign word = reg_addr[PTEI_SLOT_LSB-1:2];
    assign wr_ok = reg_wr && hit;

    // Peripheral enable register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
        end else if (wr_ok && word == PTEI_ENABLE_W) begin
            enable_q <= reg_wdata[PTEI_ENABLE_BIT];
        end
    end

    // Core events count only while enabled
    assign ev_gated = core_evt & {N_EVT{enable_q}};

    // Per event register: set by pulse, cleared by written zero
    genvar ge;
    generate
        for (ge = 0; ge < N_EVT; ge++) begin : g_evt
            assign evt_clr[ge] = wr_ok &&
                word == PTEI_EVT_W + PTEI_WORD_W'(ge) &&
                !reg_wdata[PTEI_EVT_BIT];
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    evt_q[ge] <= 1'b0;
                end else if (ev_gated[ge]) begin
                    evt_q[ge] <= 1'b1; // set wins over clear
                end else if (evt_clr[ge]) begin
                    evt_q[ge] <= 1'b0;
                end
            end
        end
    endgenerate

    // Per task software trigger on a written one
    genvar gt;
    generate
        for (gt = 0; gt < N_TASK; gt++) begin : g_task
            assign sw_task[gt] = wr_ok &&
                word == PTEI_TASK_W + PTEI_WORD_W'(gt) &&
                reg_wdata[PTEI_TRIG_BIT];
        end
    endgenerate

    // Shortcut register, one enable bit per shortcut
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            short_q <= PTEI_RESET_VAL;
        end else if (wr_ok && word == PTEI_SHORT_W) begin
            short_q <= reg_wdata;
        end
    end

    // Fixed wiring: shortcut k joins event k%N_EVT to task k%N_TASK
    always_comb begin
        sc_fire = '0;
        for (int k = 0; k < N_SHORT; k++) begin
            if (short_q[k] && ev_gated[k % N_EVT]) begin
                sc_fire[k % N_TASK] = 1'b1;
            end
        end
    end

    // Task pulses to the core from all three sources
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            task_q <= '0;
        end else begin
            task_q <= (sw_task | xbar_task_in | sc_fire) &
                      {N_TASK{enable_q}};
        end
    end

    // Event pulses to the crossbar regardless of register state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            xbar_evt_q <= '0;
        end else begin
            xbar_evt_q <= ev_gated;
        end
    end

    // Interrupt enable mask with set and clear aliases
    ptei_setclr #(
        .W(N_EVT)
    ) u_irq_enable_mask (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_main(wr_ok && HAS_MAIN && word == PTEI_IRQ_ENABLE_MASK_W),
        .wr_set(wr_ok && word == PTEI_INTSET_W),
        .wr_clr(wr_ok && word == PTEI_INTCLR_W),
        .wdata(reg_wdata[N_EVT-1:0]),
        .value(irq_enable_mask)
    );

    // One level interrupt, one cycle from event or mask change
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & irq_enable_mask);
        end
    end

    // Interrupt number equals the slot index
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pid_q <= '0;
        end else begin
            pid_q <= PID;
        end
    end

    // Read multiplexer; task words and holes read as zero
    always_comb begin
        rd_word = '0;
        if (word == PTEI_ENABLE_W) begin
            rd_word[PTEI_ENABLE_BIT] = enable_q;
        end else if (word == PTEI_SHORT_W) begin
            rd_word = short_q;
        end else if (word == PTEI_INTSET_W || word == PTEI_INTCLR_W) begin
            rd_word[N_EVT-1:0] = irq_enable_mask;
        end else if (word == PTEI_IRQ_ENABLE_MASK_W && HAS_MAIN) begin
            rd_word[N_EVT-1:0] = irq_enable_mask;
        end else begin
            for (int e = 0; e < N_EVT; e++) begin
                if (word == PTEI_EVT_W + PTEI_WORD_W'(e)) begin
                    rd_word[PTEI_EVT_BIT] = evt_q[e];
                end
            end
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd && hit;
            rdata_q <= (reg_rd && hit) ? rd_word : '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign core_task = task_q;
    assign xbar_evt_out = xbar_evt_q;
    assign irq = irq_q;
    assign irq_num = pid_q;
    assign periph_enabled = enable_q;

    // Checks
    property p_task_sw;
        @(posedge mclk) disable iff (!rst_n)
        (sw_task[0] && enable_q) |=> core_task[0];
    endproperty
    a_task_sw: assert property (p_task_sw)
        else $error("software task write did not fire");

    property p_task_off;
        @(posedge mclk) disable iff (!rst_n)
        !enable_q |=> core_task == '0;
    endproperty
    a_task_off: assert property (p_task_off)
        else $error("task fired while disabled");

    property p_evt_set;
        @(posedge mclk) disable iff (!rst_n)
        ev_gated[0] |=> evt_q[0] && xbar_evt_out[0];
    endproperty
    a_evt_set: assert property (p_evt_set)
        else $error("event pulse did not set register");

    property p_evt_hold;
        @(posedge mclk) disable iff (!rst_n)
        (evt_q[0] && !evt_clr[0]) |=> evt_q[0];
    endproperty
    a_evt_hold: assert property (p_evt_hold)
        else $error("event register lost without zero write");

    property p_evt_repeat;
        @(posedge mclk) disable iff (!rst_n)
        (evt_q[0] && core_evt[0] && enable_q) |=> xbar_evt_out[0];
    endproperty
    a_evt_repeat: assert property (p_evt_repeat)
        else $error("event pulse suppressed by set register");

    property p_short;
        @(posedge mclk) disable iff (!rst_n)
        (short_q[0] && ev_gated[0]) |=> core_task[0];
    endproperty
    a_short: assert property (p_short)
        else $error("shortcut did not trigger its task");

    property p_set_alias;
        @(posedge mclk) disable iff (!rst_n)
        (wr_ok && word == PTEI_INTSET_W) |=>
        (irq_enable_mask & $past(reg_wdata[N_EVT-1:0])) ==
        $past(reg_wdata[N_EVT-1:0]);
    endproperty
    a_set_alias: assert property (p_set_alias)
        else $error("set alias did not set mask bits");

    property p_alias_read;
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && hit && word == PTEI_INTCLR_W) |=>
        reg_rvalid && reg_rdata[N_EVT-1:0] == $past(irq_enable_mask);
    endproperty
    a_alias_read: assert property (p_alias_read)
        else $error("alias read differs from mask");

    property p_task_read;
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && hit && word == PTEI_TASK_W) |=> reg_rdata == '0;
    endproperty
    a_task_read: assert property (p_task_read)
        else $error("task register read not zero");

    property p_irq_level;
        @(posedge mclk) disable iff (!rst_n)
        ##1 irq == $past(|(evt_q & irq_enable_mask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level wrong");

    property p_irq_clear;
        @(posedge mclk) disable iff (!rst_n)
        (wr_ok && word == PTEI_INTCLR_W && reg_wdata == 32'hffff_ffff)
        |-> ##[1:4] !irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt not gone four cycles after clear");

    property p_miss;
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && !hit) |=> !reg_rvalid;
    endproperty
    a_miss: assert property (p_miss)
        else $error("answered an access outside the slot");

    c_irq: cover property (@(posedge mclk) disable iff (!rst_n)
        evt_q[0] && irq_enable_mask[0] ##1 irq);
    c_short: cover property (@(posedge mclk) disable iff (!rst_n)
        short_q[0] && ev_gated[0]);
    c_set_clr: cover property (@(posedge mclk) disable iff (!rst_n)
        ev_gated[0] && evt_clr[0]);
endmodule

// ===== tb_peripheral_task_event_interface.sv
// Self-checking bench for the task/event register bank
`timescale 1ns/1ps
module tb_peripheral_task_event_interface;
    import ptei_pkg::*;
    localparam logic [31:0] BASE = 32'h4000_5000;
    localparam logic [31:0] O_TASK = {20'h0, PTEI_TASK_W, 2'b00};
    localparam logic [31:0] O_EVT = {20'h0, PTEI_EVT_W, 2'b00};
    localparam logic [31:0] O_SHORT = {20'h0, PTEI_SHORT_W, 2'b00};
    localparam logic [31:0] O_INT = {20'h0, PTEI_IRQ_ENABLE_MASK_W, 2'b00};
    localparam logic [31:0] O_SET = {20'h0, PTEI_INTSET_W, 2'b00};
    localparam logic [31:0] O_CLR = {20'h0, PTEI_INTCLR_W, 2'b00};
    localparam logic [31:0] O_EN = {20'h0, PTEI_ENABLE_W, 2'b00};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clr_seen = 1'b0;
    logic [31:0] reg_addr = 32'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [3:0] core_evt = 4'h0;
    logic [3:0] xbar_task_in = 4'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic irq;
    logic periph_enabled;
    logic [3:0] core_task;
    logic [3:0] xbar_evt_out;
    logic [3:0] task_seen;
    logic [3:0] evt_seen;
    logic [5:0] irq_num;
    logic [7:0] irq_cycles;
    logic [31:0] rs = 32'h42;
    logic [31:0] m;
    logic [31:0] r;
    logic [31:0] v;
    logic ok;
    logic [31:0] reg_rdata_b;
    logic reg_rvalid_b;
    logic [5:0] irq_num_b;
    logic [31:0] v2;
    logic ok2;
    int mismatches = 0;
    int checks_done = 0;

    ptei_top #(.SLOT_BASE(BASE)) ptei_top_i (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .core_evt(core_evt), .core_task(core_task),
        .xbar_task_in(xbar_task_in), .xbar_evt_out(xbar_evt_out),
        .irq(irq), .irq_num(irq_num), .periph_enabled(periph_enabled)
    );
    // Peer in the next slot without main mask word, never enabled
    ptei_top #(
        .SLOT_BASE(BASE + 32'h1000),
        .HAS_MAIN(1'b0)
    ) ptei_top_nomain_i (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata_b),
        .reg_rvalid(reg_rvalid_b), .core_evt(core_evt), .core_task(),
        .xbar_task_in(xbar_task_in), .xbar_evt_out(), .irq(),
        .irq_num(irq_num_b), .periph_enabled()
    );
    ptei_far_model ptei_far_model_i (
        .mclk(mclk), .clr_seen(clr_seen), .core_task(core_task),
        .xbar_evt_out(xbar_evt_out), .irq(irq), .task_seen(task_seen),
        .evt_seen(evt_seen), .irq_cycles(irq_cycles)
    );

    // Clock at 200 MHz
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // Xorshift source for random stimulus
    function logic [31:0] nxt();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // Expected identifier from the slot base
    function logic [31:0] exp_id(input logic [31:0] b);
        return (b - PTEI_REGION_BASE) >> PTEI_SLOT_LSB;
    endfunction
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Register write, taken at the second edge
    task automatic wr(input logic [31:0] off, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= BASE + off;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Register read, answer sampled just after the taking edge
    task automatic rd(input logic [31:0] off);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= BASE + off;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        ok = reg_rvalid;
        v2 = reg_rdata_b;
        ok2 = reg_rvalid_b;
    endtask
    task automatic rdc(input logic [31:0] off, input logic [31:0] exp);
        rd(off);
        chk(ok, 1);
        chk(v, exp);
    endtask
    // One-cycle event pulse; returns just after the taking edge
    task automatic pulse_evt(input int e);
        @(posedge mclk);
        core_evt <= 4'(1 << e);
        @(posedge mclk);
        core_evt <= 4'h0;
        #1;
    endtask
    task automatic clear_seen();
        @(posedge mclk);
        clr_seen <= 1'b1;
        @(posedge mclk);
        clr_seen <= 1'b0;
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog against hangs
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk(irq_num, exp_id(BASE));
        chk(irq_num, 32'h5);
        chk(periph_enabled, 0);
        // Disabled block ignores tasks and events
        clear_seen();
        pulse_evt(0);
        chk(xbar_evt_out, 0);
        wr(O_TASK, 1);
        rdc(O_EVT, 0);
        chk(task_seen, 0);
        wr(O_EN, 1);
        #1;
        chk(periph_enabled, 1);
        // Random main, set and clear writes on the mask
        m = 0;
        for (int i = 0; i < 9; i++) begin
            r = nxt() & 32'hf;
            case (i % 3)
                0: begin wr(O_INT, r); m = r; end
                1: begin wr(O_SET, r); m = m | r; end
                default: begin wr(O_CLR, r); m = m & ~r; end
            endcase
            rdc(O_INT, m);
            rdc(O_SET, m);
            rdc(O_CLR, m);
        end
        wr(O_SET, 0);
        rdc(O_SET, m);
        wr(O_CLR, 32'hffff_ffff);
        rdc(O_CLR, 0);
        // Shortcut register holds a full word
        r = nxt();
        wr(O_SHORT, r);
        rdc(O_SHORT, r);
        wr(O_SHORT, 0);
        // Software and crossbar task triggers
        for (int t = 0; t < 4; t++) begin
            wr(O_TASK + 4 * t, 1);
            #1;
            chk(core_task, 1 << t);
            @(posedge mclk);
            xbar_task_in <= 4'(1 << t);
            @(posedge mclk);
            xbar_task_in <= 4'h0;
            #1;
            chk(core_task, 1 << t);
        end
        wr(O_TASK, 0);
        #1;
        chk(core_task, 0);
        rdc(O_TASK, 0);
        // Events set, repeat, resist a one and clear on zero
        for (int e = 0; e < 4; e++) begin
            pulse_evt(e);
            chk(xbar_evt_out, 1 << e);
            rdc(O_EVT + 4 * e, 1);
            pulse_evt(e);
            chk(xbar_evt_out, 1 << e);
            wr(O_EVT + 4 * e, 1);
            rdc(O_EVT + 4 * e, 1);
            wr(O_EVT + 4 * e, 0);
            rdc(O_EVT + 4 * e, 0);
        end
        // Interrupt follows enabled events
        clear_seen();
        wr(O_SET, 32'h4);
        pulse_evt(2);
        @(posedge mclk);
        #1;
        chk(irq, 1);
        wr(O_CLR, 32'h4);
        repeat (4) @(posedge mclk);
        #1;
        chk(irq, 0);
        wr(O_SET, 32'h2);
        repeat (4) @(posedge mclk);
        #1;
        chk(irq, 0);
        wr(O_SET, 32'h4);
        repeat (4) @(posedge mclk);
        #1;
        chk(irq, 1);
        wr(O_EVT + 8, 0);
        repeat (4) @(posedge mclk);
        #1;
        chk(irq, 0);
        chk(irq_cycles != 0, 1);
        // Shortcuts zero and one on, two off
        wr(O_SHORT, 32'h3);
        clear_seen();
        pulse_evt(0);
        pulse_evt(1);
        pulse_evt(2);
        repeat (3) @(posedge mclk);
        #1;
        chk(task_seen, 4'h3);
        chk(evt_seen, 4'h7);
        // Pulse and zero write in one cycle: the pulse wins
        fork
            pulse_evt(3);
            wr(O_EVT + 12, 0);
        join
        rdc(O_EVT + 12, 1);
        // Out-of-slot and unmapped accesses
        rd(32'h1000 + O_EVT);
        chk(ok, 0);
        wr(32'h1000 + O_EN, 0);
        #1;
        chk(periph_enabled, 1);
        rdc(32'h600, 0);
        // Peer without main word: aliases alone hold the mask
        chk(irq_num_b, exp_id(BASE + 32'h1000));
        wr(32'h1000 + O_INT, 32'hf);
        wr(32'h1000 + O_SET, 32'h5);
        wr(32'h1000 + O_CLR, 32'h1);
        rd(32'h1000 + O_SET);
        chk(ok2, 1);
        chk(v2, 32'h4);
        rd(32'h1000 + O_CLR);
        chk(v2, 32'h4);
        rd(32'h1000 + O_INT);
        chk(v2, 0);
        // Disabled again: events inert
        wr(O_EN, 0);
        pulse_evt(0);
        chk(xbar_evt_out, 0);
        wrap_up();
    end
endmodule
